// file: logic/gpd_gpio.sv
// gpio ports a to d with direction control, port a wake-up and divided clock output
`timescale 1ns/1ns
`include "gpd_defines.svh"

module gpd_gpio (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire gpd_pkg::gpd_byte_t pa_in,
   output gpd_pkg::gpd_byte_t pa_out,
   output gpd_pkg::gpd_byte_t pa_oe,
   input wire gpd_pkg::gpd_byte_t pb_in,
   output gpd_pkg::gpd_byte_t pb_out,
   output gpd_pkg::gpd_byte_t pb_oe,
   input wire gpd_pkg::gpd_byte_t pc_in,
   output gpd_pkg::gpd_byte_t pc_out,
   output gpd_pkg::gpd_byte_t pc_oe,
   input wire gpd_pkg::gpd_byte_t pd_in,
   output gpd_pkg::gpd_byte_t pd_out,
   output gpd_pkg::gpd_byte_t pd_oe,
   input wire logic sleep_mode,
   output logic wakeup_ff
);
   import gpd_pkg::*;

   gpd_byte_t pa_latch_ff, pb_latch_ff, pc_latch_ff, pd_latch_ff;
   gpd_byte_t port_a_direction_ff, port_b_direction_ff, port_c_direction_ff, port_d_direction_ff;
   gpd_byte_t port_a_wakeup_enable_ff;
   gpd_byte_t clock_output_control_ff;
   gpd_byte_t pa_sync1_ff, pa_sync2_ff, pa_prev_ff;
   logic [2:0] div_cnt_ff;
   logic cko_ff;
   logic wr_en;
   logic rd_access;
   logic addr_hit;
   logic [31:0] nxt_prdata;
   logic clock_output_select;
   gpd_ratio_t ratio;
   gpd_byte_t nxt_pc_out;
   gpd_byte_t fall;

   // port read view: output pins give the latch, input pins the live level
   function automatic gpd_byte_t port_view(gpd_byte_t latch, gpd_byte_t dir, gpd_byte_t pins,
                                            gpd_byte_t mask);
      port_view = ((latch & ~dir) | (pins & dir)) & mask;
   endfunction

   function automatic gpd_ratio_t decode_ratio(logic [1:0] code);
      case (code)
         2'b00: decode_ratio = GPD_DIV1;
         2'b01: decode_ratio = GPD_DIV2;
         2'b10: decode_ratio = GPD_DIV4;
         2'b11: decode_ratio = GPD_DIV8;
         default: decode_ratio = GPD_DIV1;
      endcase
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign clock_output_select = clock_output_control_ff[`GPD_CKO_SEL_BIT];
   assign ratio = decode_ratio({clock_output_control_ff[`GPD_CKO_RATIO_HI_BIT],
                                clock_output_control_ff[`GPD_CKO_RATIO_LO_BIT]});

   always_comb begin
      addr_hit = 1'b1;
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         `GPD_OFF_PA_DATA: nxt_prdata[7:0] = port_view(pa_latch_ff, port_a_direction_ff, pa_in, `GPD_MASK_PA);
         `GPD_OFF_PA_DIR: nxt_prdata[7:0] = port_a_direction_ff;
         `GPD_OFF_PA_WAKE: nxt_prdata[7:0] = port_a_wakeup_enable_ff;
         `GPD_OFF_PB_DATA: nxt_prdata[7:0] = port_view(pb_latch_ff, port_b_direction_ff, pb_in, `GPD_MASK_PB);
         `GPD_OFF_PB_DIR: nxt_prdata[7:0] = port_b_direction_ff;
         `GPD_OFF_PC_DATA: nxt_prdata[7:0] = port_view(pc_latch_ff, port_c_direction_ff, pc_in, `GPD_MASK_PC);
         `GPD_OFF_PC_DIR: nxt_prdata[7:0] = port_c_direction_ff;
         `GPD_OFF_PD_DATA: nxt_prdata[7:0] = port_view(pd_latch_ff, port_d_direction_ff, pd_in, `GPD_MASK_PD);
         `GPD_OFF_PD_DIR: nxt_prdata[7:0] = port_d_direction_ff;
         `GPD_OFF_CKO_CTRL: nxt_prdata[7:0] = clock_output_control_ff;
         `GPD_OFF_SLEEP: nxt_prdata[0] = wakeup_ff;
         default: addr_hit = 1'b0;
      endcase
   end

   // apb slave: zero wait states, read data captured in setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_access) begin
         prdata <= nxt_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_hit;
      end
   end

   // data latches: held until rewritten, reset high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_latch_ff <= `GPD_RST_LATCH;
         pb_latch_ff <= `GPD_RST_LATCH & `GPD_MASK_PB;
         pc_latch_ff <= `GPD_RST_LATCH & `GPD_MASK_PC;
         pd_latch_ff <= `GPD_RST_LATCH;
      end else if (wr_en) begin
         case (paddr)
            `GPD_OFF_PA_DATA: pa_latch_ff <= pwdata[7:0] & `GPD_MASK_PA;
            `GPD_OFF_PB_DATA: pb_latch_ff <= pwdata[7:0] & `GPD_MASK_PB;
            `GPD_OFF_PC_DATA: pc_latch_ff <= pwdata[7:0] & `GPD_MASK_PC;
            `GPD_OFF_PD_DATA: pd_latch_ff <= pwdata[7:0] & `GPD_MASK_PD;
            default: ;
         endcase
      end
   end

   // direction registers: unimplemented bits stay zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_direction_ff <= `GPD_RST_DIR & `GPD_MASK_PA;
         port_b_direction_ff <= `GPD_RST_DIR & `GPD_MASK_PB;
         port_c_direction_ff <= `GPD_RST_DIR & `GPD_MASK_PC;
         port_d_direction_ff <= `GPD_RST_DIR & `GPD_MASK_PD;
      end else if (wr_en) begin
         case (paddr)
            `GPD_OFF_PA_DIR: port_a_direction_ff <= pwdata[7:0] & `GPD_MASK_PA;
            `GPD_OFF_PB_DIR: port_b_direction_ff <= pwdata[7:0] & `GPD_MASK_PB;
            `GPD_OFF_PC_DIR: port_c_direction_ff <= pwdata[7:0] & `GPD_MASK_PC;
            `GPD_OFF_PD_DIR: port_d_direction_ff <= pwdata[7:0] & `GPD_MASK_PD;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_wakeup_enable_ff <= `GPD_RST_WAKE;
         clock_output_control_ff <= `GPD_RST_CKO;
      end else if (wr_en) begin
         if (paddr == `GPD_OFF_PA_WAKE) begin
            port_a_wakeup_enable_ff <= pwdata[7:0];
         end
         if (paddr == `GPD_OFF_CKO_CTRL) begin
            clock_output_control_ff <= pwdata[7:0] & `GPD_MASK_CKO;
         end
      end
   end

   // clock divider from the system clock, cleared while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_ff <= 3'h0;
         cko_ff <= 1'b0;
      end else if (!clock_output_select) begin
         div_cnt_ff <= 3'h0;
         cko_ff <= 1'b0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 3'h1;
         case (ratio)
            GPD_DIV1: cko_ff <= ~cko_ff;
            GPD_DIV2: cko_ff <= div_cnt_ff[0] ? ~cko_ff : cko_ff;
            GPD_DIV4: cko_ff <= (div_cnt_ff[1:0] == 2'h3) ? ~cko_ff : cko_ff;
            GPD_DIV8: cko_ff <= (div_cnt_ff == 3'h7) ? ~cko_ff : cko_ff;
            default: cko_ff <= 1'b0;
         endcase
      end
   end

   always_comb begin
      nxt_pc_out = pc_latch_ff;
      if (clock_output_select) begin
         nxt_pc_out[`GPD_CKO_PIN] = cko_ff & pc_latch_ff[`GPD_CKO_PIN];
      end
   end

   // pin drivers: enable high when direction bit is 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_out <= 8'h00;
         pa_oe <= 8'h00;
         pb_out <= 8'h00;
         pb_oe <= 8'h00;
         pc_out <= 8'h00;
         pc_oe <= 8'h00;
         pd_out <= 8'h00;
         pd_oe <= 8'h00;
      end else begin
         pa_out <= pa_latch_ff;
         pa_oe <= ~port_a_direction_ff & `GPD_MASK_PA;
         pb_out <= pb_latch_ff;
         pb_oe <= ~port_b_direction_ff & `GPD_MASK_PB;
         pc_out <= nxt_pc_out;
         pc_oe <= ~port_c_direction_ff & `GPD_MASK_PC;
         pd_out <= pd_latch_ff;
         pd_oe <= ~port_d_direction_ff & `GPD_MASK_PD;
      end
   end

   // port a wake: two-stage sync then falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_sync1_ff <= 8'hff;
         pa_sync2_ff <= 8'hff;
         pa_prev_ff <= 8'hff;
      end else begin
         pa_sync1_ff <= pa_in;
         pa_sync2_ff <= pa_sync1_ff;
         pa_prev_ff <= pa_sync2_ff;
      end
   end

   assign fall = pa_prev_ff & ~pa_sync2_ff & port_a_wakeup_enable_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_ff <= 1'b0;
      end else begin
         wakeup_ff <= sleep_mode && (fall != 8'h00);
      end
   end

   AST_DIR_OE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pc_oe == (~$past(port_c_direction_ff) & `GPD_MASK_PC)) else $error("oe does not follow direction");
   AST_CKO_GATED: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select && !pc_latch_ff[1] |=> !pc_out[1]) else $error("clock output not gated by latch");
   AST_DIV_HELD: assert property (@(posedge pclk) disable iff (!presetn)
      !clock_output_select |=> div_cnt_ff == 3'h0 && !cko_ff) else $error("divider runs while off");
   AST_DIV1: assert property (@(posedge pclk) disable iff (!presetn)
      $past(clock_output_select) && clock_output_select && ratio == GPD_DIV1 && $past(ratio) == GPD_DIV1
      |-> cko_ff != $past(cko_ff)) else $error("divide by one wrong");
   AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_mode && (fall != 8'h00) |=> wakeup_ff) else $error("wake missed");
   AST_NO_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (fall == 8'h00) |=> !wakeup_ff) else $error("spurious wake");
   AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
      (clock_output_control_ff & ~`GPD_MASK_CKO) == 8'h00 && port_b_direction_ff[7:6] == 2'b00)
      else $error("unimplemented bit set");
   AST_READ_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      rd_access && paddr == `GPD_OFF_PD_DATA |=> prdata[7:0] == (($past(pd_latch_ff) & ~$past(port_d_direction_ff))
      | ($past(pd_in) & $past(port_d_direction_ff)))) else $error("port read wrong");

   AST_PREADY_SET: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready) else $error("pready missing after setup");

   AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready longer than one cycle");

   AST_SLVERR_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !addr_hit |=> pslverr) else $error("unmapped access without error");

   AST_SLVERR_READY: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("error without ready");

   AST_PA_OE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pa_oe == (~$past(port_a_direction_ff) & `GPD_MASK_PA)) else $error("port a oe wrong");

   AST_PB_OE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pb_oe == (~$past(port_b_direction_ff) & `GPD_MASK_PB)) else $error("port b oe wrong");

   AST_PD_OE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pd_oe == (~$past(port_d_direction_ff) & `GPD_MASK_PD)) else $error("port d oe wrong");

   AST_PA_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pa_out == $past(pa_latch_ff)) else $error("port a out not latch");

   AST_PB_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pb_out == $past(pb_latch_ff)) else $error("port b out not latch");

   AST_PD_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pd_out == $past(pd_latch_ff)) else $error("port d out not latch");

   AST_PC_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
      !clock_output_select |=> pc_out == $past(pc_latch_ff)) else $error("port c out not latch");

   AST_PC_OTHER: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (pc_out & 8'hfd) == ($past(pc_latch_ff) & 8'hfd)) else $error("port c bits disturbed");

   AST_CKO_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select |=> pc_out[1] == ($past(cko_ff) & $past(pc_latch_ff[1]))) else $error("clock pin wrong");

   AST_PC1_OE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pc_oe[1] == !$past(port_c_direction_ff[1])) else $error("shared pin oe wrong");

   AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(pa_latch_ff) && $stable(pb_latch_ff) && $stable(pd_latch_ff)) else $error("latch lost");

   AST_DIR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(port_c_direction_ff) && $stable(port_d_direction_ff)) else $error("direction lost");

   AST_RSV_PC: assert property (@(posedge pclk) disable iff (!presetn)
      !port_c_direction_ff[7] && !clock_output_control_ff[1]) else $error("unimplemented bit set");

   AST_SYNC1: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pa_sync1_ff == $past(pa_in)) else $error("first sync stage wrong");

   AST_SYNC2: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pa_sync2_ff == $past(pa_sync1_ff)) else $error("second sync stage wrong");

   AST_DIV2_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select && ratio == GPD_DIV2 && !div_cnt_ff[0] |=> $stable(cko_ff)) else $error("divide by two");

   AST_DIV4_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select && ratio == GPD_DIV4 && div_cnt_ff[1:0] != 2'h3 |=> $stable(cko_ff))
      else $error("divide by four wrong");

   AST_DIV8_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select && ratio == GPD_DIV8 && div_cnt_ff == 3'h7 |=> cko_ff != $past(cko_ff))
      else $error("divide by eight wrong");

   AST_DIV_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_select |=> div_cnt_ff == $past(div_cnt_ff) + 3'h1) else $error("divider not counting");

   AST_WAKE_AWAKE: assert property (@(posedge pclk) disable iff (!presetn)
      !sleep_mode |=> !wakeup_ff) else $error("wake while awake");
endmodule

// file: logic/gpd_defines.svh
// register offsets, field positions, reset values and widths of the gpio block
`ifndef GPD_DEFINES_SVH
`define GPD_DEFINES_SVH
`define GPD_OFF_PA_DATA 12'h000
`define GPD_OFF_PA_DIR 12'h004
`define GPD_OFF_PA_WAKE 12'h008
`define GPD_OFF_PB_DATA 12'h00c
`define GPD_OFF_PB_DIR 12'h010
`define GPD_OFF_PC_DATA 12'h014
`define GPD_OFF_PC_DIR 12'h018
`define GPD_OFF_PD_DATA 12'h01c
`define GPD_OFF_PD_DIR 12'h020
`define GPD_OFF_CKO_CTRL 12'h024
`define GPD_OFF_SLEEP 12'h028
`define GPD_MASK_PA 8'hff
`define GPD_MASK_PB 8'h3f
`define GPD_MASK_PC 8'h7f
`define GPD_MASK_PD 8'hff
`define GPD_MASK_CKO 8'h1d
`define GPD_RST_LATCH 8'hff
`define GPD_RST_DIR 8'hff
`define GPD_RST_WAKE 8'h00
`define GPD_RST_CKO 8'h00
`define GPD_CKO_SEL_BIT 4
`define GPD_CKO_RATIO_HI_BIT 3
`define GPD_CKO_RATIO_LO_BIT 2
`define GPD_CKO_DRIVE_BIT 0
`define GPD_CKO_PIN 1
`endif

// file: logic/gpd_pkg.sv
// types shared by the gpio block
package gpd_pkg;
   typedef logic [7:0] gpd_byte_t;
   typedef enum logic [3:0] {
      GPD_DIV1 = 4'b0001,
      GPD_DIV2 = 4'b0010,
      GPD_DIV4 = 4'b0100,
      GPD_DIV8 = 4'b1000
   } gpd_ratio_t;
endpackage

// file: dv/gpd_pin_model.sv
// far-side circuitry: each pin shows the design's value where driven, else the external driver
`timescale 1ns/1ns
module gpd_pin_model (
   input wire gpd_pkg::gpd_byte_t pin_out,
   input wire gpd_pkg::gpd_byte_t pin_oe,
   input wire gpd_pkg::gpd_byte_t ext_drv,
   output gpd_pkg::gpd_byte_t pin_lvl
);
   import gpd_pkg::*;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_drv[i];
      end
   end
endmodule

// file: dv/testbench.sv
// self-checking bench for the gpio block
`timescale 1ns/1ns
`include "gpd_defines.svh"
module testbench;
   import gpd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, wakeup_ff, err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   gpd_byte_t pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe;
   gpd_byte_t ext_a, ext_b, ext_c, ext_d;
   int err_total, compares, n;
   gpd_gpio dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
      .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
      .sleep_mode(sleep_mode), .wakeup_ff(wakeup_ff));
   gpd_pin_model pma (.pin_out(pa_out), .pin_oe(pa_oe), .ext_drv(ext_a), .pin_lvl(pa_in));
   gpd_pin_model pmb (.pin_out(pb_out), .pin_oe(pb_oe), .ext_drv(ext_b), .pin_lvl(pb_in));
   gpd_pin_model pmc (.pin_out(pc_out), .pin_oe(pc_oe), .ext_drv(ext_c), .pin_lvl(pc_in));
   gpd_pin_model pmd (.pin_out(pd_out), .pin_oe(pd_oe), .ext_drv(ext_d), .pin_lvl(pd_in));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err_seen = pslverr;
      chk("pready", pready, 1);
      psel <= 1'b0;
      penable <= 1'b0;
      // the pins follow a written register one edge after the access edge
      cyc(2);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      apb(1'b0, a, 32'h0, rd);
      chk(what, rd, exp);
   endtask
   // cycles between the first two rising edges of the shared clock pin, 0 if none
   task automatic period(output int p);
      int first;
      logic prev;
      first = -1;
      p = 0;
      prev = pc_out[1];
      for (int i = 1; i < 40; i++) begin
         @(posedge pclk);
         if (pc_out[1] === 1'b1 && prev === 1'b0) begin
            if (first >= 0 && p == 0) p = i - first;
            if (first < 0) first = i;
         end
         prev = pc_out[1];
      end
   endtask
   // drop port a to v, count wake pulses, then restore the idle high level
   task automatic pulses(input gpd_byte_t v, output int c);
      c = 0;
      ext_a <= v;
      repeat (8) begin
         @(posedge pclk);
         if (wakeup_ff === 1'b1) c++;
      end
      ext_a <= 8'hff;
      cyc(5);
   endtask
   task automatic t_reset;
      rdchk("pb dir", `GPD_OFF_PB_DIR, 32'h3f);
      rdchk("pc dir", `GPD_OFF_PC_DIR, 32'h7f);
      rdchk("pd dir", `GPD_OFF_PD_DIR, 32'hff);
      rdchk("cko ctrl", `GPD_OFF_CKO_CTRL, 32'h0);
      chk("oe", {pa_oe, pb_oe, pc_oe, pd_oe}, 32'h0);
      chk("pa out", pa_out, 8'hff);
   endtask
   // software read-modify-write of one port bit
   task automatic t_rmw;
      logic [31:0] rd;
      wr(`GPD_OFF_PD_DIR, 32'h0);
      wr(`GPD_OFF_PD_DATA, 32'ha5);
      apb(1'b0, `GPD_OFF_PD_DATA, 32'h0, rd);
      wr(`GPD_OFF_PD_DATA, rd | 32'h10);
      chk("pd out", pd_out, 8'hb5);
      chk("pd oe", pd_oe, 8'hff);
      rdchk("wake flag", `GPD_OFF_SLEEP, 32'h0);
   endtask
   task automatic t_pins;
      logic [31:0] rd;
      ext_b <= 8'h2a;
      wr(`GPD_OFF_PB_DIR, 32'hffffffc0);
      rdchk("pb dir", `GPD_OFF_PB_DIR, 32'h0);
      chk("pb oe", pb_oe, 8'h3f);
      chk("pb out", pb_out, 8'h3f);
      wr(`GPD_OFF_PB_DATA, 32'h05);
      wr(`GPD_OFF_PB_DIR, 32'h30);
      chk("pb oe", pb_oe, 8'h0f);
      chk("pb out", pb_out & pb_oe, 8'h05);
      rdchk("pb data", `GPD_OFF_PB_DATA, 32'h25);
      ext_b <= 8'h10;
      rdchk("pb data", `GPD_OFF_PB_DATA, 32'h15);
      wr(`GPD_OFF_CKO_CTRL, 32'hff);
      rdchk("cko ctrl", `GPD_OFF_CKO_CTRL, 32'h1d);
      apb(1'b0, 12'h030, 32'h0, rd);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped err", err_seen, 1);
   endtask
   task automatic t_cko;
      int p;
      wr(`GPD_OFF_CKO_CTRL, 32'h0);
      wr(`GPD_OFF_PC_DIR, 32'h7d);
      chk("pc1 plain", pc_out[1], 1);
      for (int c = 0; c < 4; c++) begin
         wr(`GPD_OFF_CKO_CTRL, 32'h10 | (c << 2));
         period(p);
         chk("cko period", p, 2 << c);
      end
      chk("pc1 oe", pc_oe[1], 1);
      wr(`GPD_OFF_PC_DATA, 32'h7d);
      period(p);
      chk("gated period", p, 0);
      chk("gated level", pc_out[1], 0);
      wr(`GPD_OFF_PC_DIR, 32'h7f);
      ext_c <= 8'h02;
      rdchk("pc data", `GPD_OFF_PC_DATA, 32'h02);
      chk("pc oe", pc_oe, 8'h0);
   endtask
   task automatic t_wake;
      int c;
      wr(`GPD_OFF_PA_WAKE, 32'h08);
      rdchk("wake en", `GPD_OFF_PA_WAKE, 32'h08);
      sleep_mode <= 1'b1;
      pulses(8'hf7, c);
      chk("wake enabled", c, 1);
      pulses(8'hfb, c);
      chk("wake disabled pin", c, 0);
      sleep_mode <= 1'b0;
      pulses(8'hf7, c);
      chk("wake awake", c, 0);
   endtask
   initial begin
      {psel, penable, pwrite, sleep_mode, presetn} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {ext_a, ext_b, ext_c, ext_d} = 32'hffffffff;
      err_total = 0;
      compares = 0;
      cyc(2);
      presetn <= 1'b1;
      t_reset();
      t_pins();
      t_cko();
      t_wake();
      t_rmw();
      give_verdict();
   end
   initial begin
      #500000;
      err_total++;
      give_verdict();
   end
endmodule
